/* hdl/arf_top.sv */
// Auto restart sequencer and fire mode control with AXI4-Lite registers
// Functional notes
// RULE1 - Restart setting zero: run automatically after every power-on or reset.
// RULE2 - Setting one to five: after trip, retry that many times, 20 s apart.
// RULE3 - Count attempts; failed final attempt latches fault until manual reset.
// RULE4 - Attempt counter cleared only by power-down, not by fault reset.
// RULE5 - Fire polarity and latch act only for fire input selections 15 to 18.
// RULE6 - Logic option 0: normally-closed, fire mode while contact open.
// RULE7 - Logic option 1: normally-open, fire mode while contact closed.
// RULE8 - Latch option 0: fire mode only while conditioned input stays active.
// RULE9 - Latch option 1: pulse enters fire mode until disabled or power off; the code also clears the latch on aresetn.
// RULE10 - Synchronise fire input to the clock before polarity and latching.
`timescale 1ns/1ps
`default_nettype none
`include "arf_defs.svh"

module arf_top (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 por_n,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output var  logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output var  logic                 s_axi_wready,
  output var  logic [1:0]           s_axi_bresp,
  output var  logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output var  logic                 s_axi_arready,
  output var  logic [31:0]          s_axi_rdata,
  output var  logic [1:0]           s_axi_rresp,
  output var  logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire arf_pkg::arf_drive_t  drive_fb,
  input  wire logic                 fire_contact_closed,
  output var  logic                 run_cmd,
  output var  logic                 fault_latched,
  output var  logic                 fire_mode,
  output var  logic                 irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  arf_pkg::arf_ctrl_t  ctrl_q, ctrl_d;
  arf_pkg::arf_state_t st_q, st_d;
  logic [31:0] tmr_q, tmr_d;
  logic [2:0]  att_q, att_d;
  logic        run_q, run_d;
  logic        flt_q, flt_d;
  logic        fire_q, fire_d;
  logic        irq_q, irq_d;
  logic [`ARF_IRQ_W-1:0] ist_q, ist_d;
  logic [`ARF_IRQ_W-1:0] imsk_q, imsk_d;
  logic [`ARF_IRQ_W-1:0] ev;
  logic        aw_q, aw_d, w_q, w_d, b_q, b_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        r_q, r_d;
  logic [31:0] rdat_q, rdat_d;
  logic [1:0]  rresp_q, rresp_d;
  logic        wr_go, rd_go;
  logic        cmd_start, cmd_freset, cmd_fdis;
  logic        fire_now;
  logic [31:0] imsk_w;

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Known register offset check
  function automatic logic mapped(input logic [7:0] a);
    return (a == `ARF_ADDR_CTRL) || (a == `ARF_ADDR_CMD) || (a == `ARF_ADDR_STATUS) ||
           (a == `ARF_ADDR_IRQ_STAT) || (a == `ARF_ADDR_IRQ_MASK);
  endfunction

  // ----------------------------------------------------------------
  // Fire mode conditioning
  // ----------------------------------------------------------------
  arf_fire_cond u_fire (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .fire_contact_closed (fire_contact_closed),
    .ctrl                (ctrl_q),
    .fire_disable        (cmd_fdis),
    .fire_active         (fire_now)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign wr_go      = aw_q && w_q && !b_q;
  assign rd_go      = s_axi_arvalid && s_axi_arready;
  assign cmd_start  = wr_go && (awa_q == `ARF_ADDR_CMD) && ws_q[0] &&
                      wd_q[`ARF_CMD_START_BIT];
  assign cmd_freset = wr_go && (awa_q == `ARF_ADDR_CMD) && ws_q[0] &&
                      wd_q[`ARF_CMD_FRESET_BIT];
  assign cmd_fdis   = wr_go && (awa_q == `ARF_ADDR_CMD) && ws_q[0] &&
                      wd_q[`ARF_CMD_FDIS_BIT];

  // Bus next values: capture address and data in either order, then respond
  always_comb begin
    imsk_w = merge({29'h0, imsk_q}, wd_q, ws_q);
    aw_d = aw_q;
    w_d = w_q;
    b_d = b_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bresp_d = bresp_q;
    r_d = r_q;
    rdat_d = rdat_q;
    rresp_d = rresp_q;
    ctrl_d = ctrl_q;
    imsk_d = imsk_q;
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_go) begin
      b_d = 1'b1;
      bresp_d = mapped(awa_q) ? `ARF_RESP_OKAY : `ARF_RESP_SLVERR;
      if (awa_q == `ARF_ADDR_CTRL) begin
        ctrl_d.auto_restart_max_attempts_setting = ws_q[0] ?
          wd_q[`ARF_CTRL_RST_LSB +: 3] : ctrl_q.auto_restart_max_attempts_setting;
        ctrl_d.fire_logic = ws_q[0] ? wd_q[`ARF_CTRL_LOGIC_BIT] : ctrl_q.fire_logic;
        ctrl_d.fire_latch = ws_q[0] ? wd_q[`ARF_CTRL_LATCH_BIT] : ctrl_q.fire_latch;
        ctrl_d.fire_sel = ws_q[1] ? wd_q[`ARF_CTRL_FSEL_LSB +: 5] : ctrl_q.fire_sel;
      end
      if (awa_q == `ARF_ADDR_IRQ_MASK) begin
        imsk_d = imsk_w[`ARF_IRQ_W-1:0];
      end
    end
    if (b_q && s_axi_bready) begin
      b_d = 1'b0;
      aw_d = 1'b0;
      w_d = 1'b0;
    end
    if (rd_go) begin
      r_d = 1'b1;
      rresp_d = mapped(s_axi_araddr) ? `ARF_RESP_OKAY : `ARF_RESP_SLVERR;
      case (s_axi_araddr)
        `ARF_ADDR_CTRL: begin
          rdat_d = {19'h0, ctrl_q.fire_sel, 3'h0, ctrl_q.fire_latch, ctrl_q.fire_logic,
                    ctrl_q.auto_restart_max_attempts_setting};
        end
        `ARF_ADDR_STATUS: begin
          rdat_d = {24'h0, 1'b0, att_q, flt_q, fire_q, run_q, 1'b0};
        end
        `ARF_ADDR_IRQ_STAT: begin
          rdat_d = {29'h0, ist_q};
        end
        `ARF_ADDR_IRQ_MASK: begin
          rdat_d = {29'h0, imsk_q};
        end
        default: begin
          rdat_d = 32'h0000_0000;
        end
      endcase
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      bresp_q <= `ARF_RESP_OKAY;
      r_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      rresp_q <= `ARF_RESP_OKAY;
      ctrl_q <= arf_pkg::arf_ctrl_t'(10'(`ARF_CTRL_RESET));
      imsk_q <= 3'h0;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bresp_q <= bresp_d;
      r_q <= r_d;
      rdat_q <= rdat_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
      imsk_q <= imsk_d;
    end
  end

  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_bvalid  = b_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid  = r_q;
  assign s_axi_rdata   = rdat_q;
  assign s_axi_rresp   = rresp_q;

  // ----------------------------------------------------------------
  // Restart sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    att_d = att_q;
    run_d = run_q;
    flt_d = flt_q;
    ev = '0;
    case (st_q)
      arf_pkg::ARF_IDLE: begin
        run_d = 1'b0;
        if (cmd_start || ctrl_q.auto_restart_max_attempts_setting == `ARF_RST_AUTO_RUN) begin
          st_d = arf_pkg::ARF_RUN;                                       // [RULE1]
          run_d = 1'b1;
        end
      end
      arf_pkg::ARF_RUN: begin
        if (drive_fb.trip) begin
          run_d = 1'b0;
          st_d = arf_pkg::ARF_TRIPPED;
        end
      end
      arf_pkg::ARF_TRIPPED: begin
        if (ctrl_q.auto_restart_max_attempts_setting == `ARF_RST_AUTO_RUN ||
            ctrl_q.auto_restart_max_attempts_setting > `ARF_RST_MAX) begin
          if (cmd_freset) begin
            st_d = arf_pkg::ARF_IDLE;
          end
        end else if (att_q >= ctrl_q.auto_restart_max_attempts_setting) begin
          st_d = arf_pkg::ARF_LOCKOUT;                                   // [RULE3]
          flt_d = 1'b1;
          ev[`ARF_IRQ_LOCKOUT] = 1'b1;
        end else begin
          st_d = arf_pkg::ARF_WAIT;
          tmr_d = 32'(`ARF_RETRY_CYC - 1);                               // [RULE2]
        end
      end
      arf_pkg::ARF_WAIT: begin
        if (tmr_q == 32'h0000_0000) begin
          st_d = arf_pkg::ARF_TRY;
          att_d = att_q + 3'h1;                                          // [RULE3]
          run_d = 1'b1;
          tmr_d = `ARF_START_WAIT_CYC;
          ev[`ARF_IRQ_ATTEMPT] = 1'b1;
        end else begin
          tmr_d = tmr_q - 32'h0000_0001;
        end
      end
      arf_pkg::ARF_TRY: begin
        if (drive_fb.trip) begin
          run_d = 1'b0;
          st_d = arf_pkg::ARF_TRIPPED;
        end else if (drive_fb.running) begin
          st_d = arf_pkg::ARF_RUN;
        end else if (tmr_q == 32'h0000_0000) begin
          run_d = 1'b0;
          st_d = arf_pkg::ARF_TRIPPED;
        end else begin
          tmr_d = tmr_q - 32'h0000_0001;
        end
      end
      arf_pkg::ARF_LOCKOUT: begin
        if (cmd_freset) begin
          flt_d = 1'b0;                                                  // [RULE3]
          st_d = arf_pkg::ARF_IDLE;                                      // [RULE4]
        end
      end
      default: begin
        st_d = arf_pkg::ARF_IDLE;
      end
    endcase
    fire_d = fire_now;
    ev[`ARF_IRQ_FIRE] = fire_now && !fire_q;
    // Sticky status: read clears, new event wins
    ist_d = ist_q;
    if (rd_go && s_axi_araddr == `ARF_ADDR_IRQ_STAT) begin
      ist_d = '0;
    end
    ist_d = ist_d | ev;
    irq_d = |(ist_d & imsk_q);
  end

  // Sequencer registers; attempt count survives aresetn, cleared by power-on only
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      att_q <= 3'h0;                                                     // [RULE4]
    end else begin
      att_q <= att_d;                                                    // [RULE4]
    end
    if (!aresetn) begin
      st_q <= arf_pkg::ARF_IDLE;
      tmr_q <= 32'h0000_0000;
      run_q <= 1'b0;
      flt_q <= 1'b0;
      fire_q <= 1'b0;
      ist_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      run_q <= run_d;
      flt_q <= flt_d;
      fire_q <= fire_d;
      ist_q <= ist_d;
      irq_q <= irq_d;
    end
  end

  assign run_cmd       = run_q;
  assign fault_latched = flt_q;
  assign fire_mode     = fire_q;
  assign irq           = irq_q;

endmodule

`default_nettype wire

/* hdl/arf_defs.svh */
// Constants for the auto restart and fire mode block
`ifndef ARF_DEFS_SVH
`define ARF_DEFS_SVH

// Register byte offsets
`define ARF_ADDR_CTRL      8'h00
`define ARF_ADDR_CMD       8'h04
`define ARF_ADDR_STATUS    8'h08
`define ARF_ADDR_IRQ_STAT  8'h0C
`define ARF_ADDR_IRQ_MASK  8'h10

// Control register fields
`define ARF_CTRL_RST_LSB   0
`define ARF_CTRL_LOGIC_BIT 3
`define ARF_CTRL_LATCH_BIT 4
`define ARF_CTRL_FSEL_LSB  8
`define ARF_CTRL_RESET     32'h0000_0000

// Command register bits (write one to act)
`define ARF_CMD_START_BIT  0
`define ARF_CMD_FRESET_BIT 1
`define ARF_CMD_FDIS_BIT   2

// Interrupt status bits
`define ARF_IRQ_ATTEMPT    0
`define ARF_IRQ_LOCKOUT    1
`define ARF_IRQ_FIRE       2
`define ARF_IRQ_W          3

// Restart setting values
`define ARF_RST_AUTO_RUN   3'h0
`define ARF_RST_MAX        3'h5

// Fire mode input function selections
`define ARF_FSEL_FIRE_LO   5'h0F
`define ARF_FSEL_FIRE_HI   5'h12

// Restart interval timing
`define ARF_CLK_HZ         25000000
`define ARF_RETRY_S        20
`define ARF_RETRY_CYC      (`ARF_CLK_HZ * `ARF_RETRY_S)
`define ARF_START_WAIT_CYC 32'h0000_0100

// AXI responses
`define ARF_RESP_OKAY      2'h0
`define ARF_RESP_SLVERR    2'h2

`endif

/* hdl/arf_pkg.sv */
// Types for the auto restart and fire mode block
package arf_pkg;

  // Restart sequencer states
  typedef enum logic [2:0] {
    ARF_IDLE,
    ARF_RUN,
    ARF_TRIPPED,
    ARF_WAIT,
    ARF_TRY,
    ARF_LOCKOUT
  } arf_state_t;

  // Software control fields
  typedef struct packed {
    logic [4:0] fire_sel;
    logic       fire_latch;
    logic       fire_logic;
    logic [2:0] auto_restart_max_attempts_setting;
  } arf_ctrl_t;

  // Drive feedback from the motor control
  typedef struct packed {
    logic trip;
    logic running;
  } arf_drive_t;

endpackage

/* hdl/arf_fire_cond.sv */
// Fire mode input synchroniser, polarity and latch conditioning
`timescale 1ns/1ps
`default_nettype none
`include "arf_defs.svh"

module arf_fire_cond (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              fire_contact_closed,
  input  wire arf_pkg::arf_ctrl_t ctrl,
  input  wire logic              fire_disable,
  output var  logic              fire_active
);

  logic sync1_q, sync1_d;
  logic sync2_q, sync2_d;
  logic latch_q, latch_d;
  logic func_ok;
  logic cond;

  // ----------------------------------------------------------------
  // Conditioning
  // ----------------------------------------------------------------

  // Input function must assign a fire mode input
  assign func_ok = (ctrl.fire_sel >= `ARF_FSEL_FIRE_LO) &&
                   (ctrl.fire_sel <= `ARF_FSEL_FIRE_HI);                 // [RULE5]
  // Open contact active for logic 0, closed contact active for logic 1
  assign cond = func_ok && (ctrl.fire_logic ? sync2_q : ~sync2_q);      // [RULE6] [RULE7]

  // Next values
  always_comb begin
    sync1_d = fire_contact_closed;                                      // [RULE10]
    sync2_d = sync1_q;                                                  // [RULE10]
    latch_d = latch_q;
    if (!func_ok || !ctrl.fire_latch || fire_disable) begin
      latch_d = 1'b0;
    end else if (cond) begin
      latch_d = 1'b1;                                                   // [RULE9]
    end
    // Maintained mode follows input, momentary mode holds
    fire_active = cond || (ctrl.fire_latch && latch_q);                 // [RULE8] [RULE9]
  end

  // Registers; a closed contact is the idle state for the synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      latch_q <= 1'b0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      latch_q <= latch_d;
    end
  end

endmodule

`default_nettype wire

/* testbench/arf_top_asserts.sv */
// Port checker for the auto restart and fire mode block
`timescale 1ns/1ps
`default_nettype none
`include "arf_defs.svh"
module arf_top_asserts (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic [7:0]         s_axi_awaddr,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic [31:0]        s_axi_wdata,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire arf_pkg::arf_drive_t drive_fb,
  input wire logic               fire_contact_closed,
  input wire logic               run_cmd,
  input wire logic               fire_mode
);
  logic [7:0]  aw_q;
  logic [31:0] wd_q;
  logic [12:0] ctrl_q;
  logic        wr_q;
  logic        act;
  logic        en;
  logic        cond;
  // Shadow of the control word and of a write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ctrl_q <= 13'h0000;
      wr_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
      if (s_axi_awvalid && s_axi_awready) wr_q <= 1'b1;
      else if (s_axi_bvalid && s_axi_bready) wr_q <= 1'b0;
      if (s_axi_bvalid && s_axi_bready && aw_q == `ARF_ADDR_CTRL) ctrl_q <= wd_q[12:0];
    end
  end
  // Decoded fire input settings
  assign act  = wr_q | s_axi_awvalid;
  assign en   = ctrl_q[12:8] >= `ARF_FSEL_FIRE_LO && ctrl_q[12:8] <= `ARF_FSEL_FIRE_HI;
  assign cond = ctrl_q[3] ? fire_contact_closed : !fire_contact_closed;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence steady_s(logic c);
    (c && !act) [*4];
  endsequence
  sequence quiet_edge_s;
    $stable(fire_contact_closed) [*3] ##1 ($changed(fire_contact_closed) && !act);
  endsequence
  fire_nc_a: assert property (steady_s(en && !ctrl_q[3] && !fire_contact_closed) |=> fire_mode)
    else $error("fire mode missing with open contact");
  fire_no_a: assert property (steady_s(en && ctrl_q[3] && fire_contact_closed) |=> fire_mode)
    else $error("fire mode missing with closed contact");
  fire_sel_a: assert property (steady_s(!en) |=> !fire_mode)
    else $error("fire mode with no fire input selected");
  fire_hold_a: assert property (steady_s(en && !ctrl_q[4] && !cond) |=> !fire_mode)
    else $error("maintained fire mode kept after input left");
  fire_latch_a: assert property (fire_mode && en && ctrl_q[4] && !act |=> fire_mode)
    else $error("momentary fire mode dropped");
  sync_delay_a: assert property (quiet_edge_s |=> $stable(fire_mode))
    else $error("fire mode followed contact too fast");
  run_auto_a: assert property (!$past(aresetn) && !drive_fb.trip |-> ##[0:16] run_cmd)
    else $error("no automatic run after reset");
  trip_stop_a: assert property (drive_fb.trip && run_cmd |=> !run_cmd)
    else $error("run request kept after trip");
  read_err_a: assert property (s_axi_rvalid && s_axi_rresp == `ARF_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  read_lat_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer not one cycle after address");
endmodule
bind arf_top arf_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .drive_fb(drive_fb), .fire_contact_closed(fire_contact_closed),
  .run_cmd(run_cmd), .fire_mode(fire_mode));
`default_nettype wire

/* testbench/arf_contact_model.sv */
// Field contact on the fire input, moving after a chosen lag
`timescale 1ns/1ps
`default_nettype none
module arf_contact_model (
  input wire logic       aclk,
  input wire logic       want_closed,
  input wire logic [3:0] lag,
  output var logic       fire_contact_closed
);
  logic [3:0] cnt_q;
  initial fire_contact_closed = 1'b1;
  initial cnt_q = 4'h0;
  // Contact moves lag+1 cycles after it is asked, on the next edge when lag is zero
  always @(posedge aclk) begin
    if (fire_contact_closed == want_closed) cnt_q <= lag;
    else if (cnt_q == 4'h0) fire_contact_closed <= want_closed;
    else cnt_q <= cnt_q - 4'h1;
  end
endmodule
`default_nettype wire

/* testbench/test_auto_restart_fire_mode.sv */
// Testbench for the auto restart and fire mode block
`timescale 1ns/1ps
`default_nettype none
`include "arf_defs.svh"
module test_auto_restart_fire_mode;
  logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF, lag = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, want = 1'b1, contact, run, fault, fire, irq;
  logic trip = 1'b0;
  logic [1:0] bresp, rresp, rr;
  logic [4:0] sel;
  arf_pkg::arf_drive_t fb = 2'h0;
  int n_mismatch = 0, n_tests = 0, seed = 27;
  arf_top dut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .drive_fb(fb), .fire_contact_closed(contact), .run_cmd(run),
    .fault_latched(fault), .fire_mode(fire), .irq(irq));
  arf_contact_model u_contact (.aclk(aclk), .want_closed(want), .lag(lag),
    .fire_contact_closed(contact));
  // Clock and a motor that runs whenever asked
  always #20 aclk = ~aclk;
  always @(posedge aclk) fb <= {trip, run};
  function automatic logic exp_fire(logic lg, logic closed);
    return lg ? closed : !closed;
  endfunction
  function automatic logic [31:0] ctrl_w(logic [4:0] s, logic lt, logic lg);
    return {19'h0, s, 3'h0, lt, lg, 3'h0};
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge aclk);
  endtask
  // Motor trip held for a few cycles, then cleared
  task automatic trip_pulse;
    trip <= 1'b1; cyc(4); trip <= 1'b0; cyc(4);
  endtask
  // Bus write: address and data together, response waited for
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata; rr = rresp; rready <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    cyc(30000);
    n_mismatch++;
    end_of_test;
  end
  // Main sequence
  initial begin
    cyc(8);
    aresetn <= 1'b1; por_n <= 1'b1;
    rd_reg(`ARF_ADDR_CTRL); chk(rd, `ARF_CTRL_RESET);
    cyc(16); chk(run, 1'b1);
    rd_reg(8'h20); chk(rr, `ARF_RESP_SLVERR); chk(rd, 32'h0);
    wr_reg(`ARF_ADDR_IRQ_MASK, 32'h4);
    for (int i = 0; i < 4; i++) begin
      sel = `ARF_FSEL_FIRE_LO + 5'(i);
      lag <= 4'($random(seed));
      wr_reg(`ARF_ADDR_CTRL, ctrl_w(sel, 1'b0, i[0]));
      for (int c = 0; c < 2; c++) begin
        want <= c[0]; cyc(24); chk(fire, exp_fire(i[0], c[0]));
      end
    end
    rd_reg(`ARF_ADDR_STATUS); chk(rd[2], 1'b1);
    want <= 1'b0; cyc(24);
    rd_reg(`ARF_ADDR_IRQ_STAT); cyc(2); chk(irq, 1'b0);
    want <= 1'b1; cyc(24); chk(irq, 1'b1);
    rd_reg(`ARF_ADDR_IRQ_STAT); chk(rd[2], 1'b1); cyc(2); chk(irq, 1'b0);
    wr_reg(`ARF_ADDR_IRQ_MASK, 32'h0); want <= 1'b0; cyc(24); want <= 1'b1; cyc(24);
    chk(irq, 1'b0); rd_reg(`ARF_ADDR_IRQ_STAT); chk(rd[2], 1'b1);
    wr_reg(`ARF_ADDR_CTRL, ctrl_w(5'h10, 1'b1, 1'b1)); want <= 1'b0; cyc(24);
    want <= 1'b1; cyc(24); want <= 1'b0; cyc(24); chk(fire, 1'b1);
    wr_reg(`ARF_ADDR_CMD, 32'h1 << `ARF_CMD_FDIS_BIT); cyc(4); chk(fire, 1'b0);
    for (int i = 0; i < 3; i++) begin
      sel = (i == 0) ? 5'h0E : (i == 1) ? 5'h13 : 5'($random(seed));
      if (sel >= `ARF_FSEL_FIRE_LO && sel <= `ARF_FSEL_FIRE_HI) sel = sel ^ 5'h10;
      wr_reg(`ARF_ADDR_CTRL, ctrl_w(sel, 1'b0, 1'b0)); want <= 1'b0;
      cyc(24); chk(fire, 1'b0);
    end
    // Trip with setting zero waits for a fault reset, then runs by itself
    trip_pulse; chk(run, 1'b0); chk(fault, 1'b0);
    wr_reg(`ARF_ADDR_CMD, 32'h1 << `ARF_CMD_FRESET_BIT); cyc(4); chk(run, 1'b1);
    // Low byte only: no retries, input selection kept
    wstrb <= 4'h1; wr_reg(`ARF_ADDR_CTRL, 32'h0000_1F06); wstrb <= 4'hF;
    rd_reg(`ARF_ADDR_CTRL); chk(rd, {19'h0, sel, 8'h06});
    trip_pulse; wr_reg(`ARF_ADDR_CMD, 32'h1 << `ARF_CMD_FRESET_BIT); cyc(8);
    chk(run, 1'b0);
    wr_reg(`ARF_ADDR_CMD, 32'h1 << `ARF_CMD_START_BIT); cyc(4); chk(run, 1'b1);
    // One retry allowed: interval wait, no fault, no attempt counted yet
    wr_reg(`ARF_ADDR_CTRL, 32'h1); trip_pulse; cyc(16);
    chk(run, 1'b0); chk(fault, 1'b0);
    rd_reg(`ARF_ADDR_STATUS); chk(rd[6:4], 3'h0);
    aresetn <= 1'b0; cyc(2); aresetn <= 1'b1;
    cyc(16); chk(run, 1'b1);
    end_of_test;
  end
endmodule
`default_nettype wire
